/* File: lsau_pkg.sv */
// package: register map and field constants of the limit status alert unit
package lsau_pkg;
	// ---------------------------------------------------------------
	// sizes
	// ---------------------------------------------------------------
	localparam int NUM_STATUS = 8;
	localparam int NUM_DUP = 6;
	localparam int NUM_MASK = 7;
	localparam int NUM_FAN_OUT = 4;
	localparam int NUM_FAN_IN = 8;
	localparam int DUTY_W = 8;

	// ---------------------------------------------------------------
	// mask registers
	// ---------------------------------------------------------------
	localparam logic [7:0] THERMAL_MASK_ONE = 8'h30;
	localparam logic [7:0] THERMAL_MASK_TWO = 8'h31;
	localparam logic [7:0] VOLTAGE_MASK_ONE = 8'h32;
	localparam logic [7:0] VOLTAGE_MASK_TWO = 8'h33;
	localparam logic [7:0] FAN_FAULT_MASK = 8'h34;
	localparam logic [7:0] DIGITAL_FAULT_MASK = 8'h35;
	localparam logic [7:0] GPIO_EVENT_MASK = 8'h36;
	localparam logic [7:0] MASK_BASE = THERMAL_MASK_ONE;
	localparam logic [7:0] MASK_RESET = 8'h00;

	// ---------------------------------------------------------------
	// status registers, host copy and duplicate copy
	// ---------------------------------------------------------------
	localparam logic [7:0] THERMAL_FLAGS_ONE_HOST = 8'hB8;
	localparam logic [7:0] THERMAL_FLAGS_TWO_HOST = 8'hB9;
	localparam logic [7:0] THERMAL_FLAGS_THREE_HOST = 8'hBA;
	localparam logic [7:0] VOLTAGE_FLAGS_ONE_HOST = 8'hBB;
	localparam logic [7:0] VOLTAGE_FLAGS_TWO_HOST = 8'hBC;
	localparam logic [7:0] FAN_FLAGS_HOST = 8'hBD;
	localparam logic [7:0] DIGITAL_FLAGS_HOST = 8'hBE;
	localparam logic [7:0] GPIO_FLAGS_HOST = 8'hBF;
	localparam logic [7:0] HOST_BASE = THERMAL_FLAGS_ONE_HOST;
	localparam logic [7:0] THERMAL_FLAGS_ONE_SECOND = 8'hC0;
	localparam logic [7:0] THERMAL_FLAGS_TWO_SECOND = 8'hC1;
	localparam logic [7:0] VOLTAGE_FLAGS_ONE_SECOND = 8'hC3;
	localparam logic [7:0] VOLTAGE_FLAGS_TWO_SECOND = 8'hC4;
	localparam logic [7:0] FAN_FLAGS_SECOND = 8'hC5;
	localparam logic [7:0] DIGITAL_FLAGS_SECOND = 8'hC6;
	localparam logic [7:0] SECOND_BASE = THERMAL_FLAGS_ONE_SECOND;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	// status slots that have a duplicate copy
	localparam logic [7:0] DUP_PRESENT = 8'h7B;
	// status slot of the gpio flags, which has the thermal three mask gap before it
	localparam int GPIO_SLOT = 7;
	localparam int THERMAL_THREE_SLOT = 2;

	// ---------------------------------------------------------------
	// fan drive
	// ---------------------------------------------------------------
	localparam logic [3:0] FAN_MODE_RESET = 4'h0;
	localparam logic [7:0] DUTY_RESET = 8'hFF;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : lsau_pkg

/* File: lsau_core.sv */
// module: sticky limit flags, alert generation and fan drive of the monitor
//
// Behaviour
// - every temperature and voltage reading is compared to its limits and lands in a flag bit.
// - a flag bit of zero means in limit and one means out of limit.
// - a set flag holds until its register is read, even if the reading recovers.
// - reading a flag register clears each set bit whose fault is gone and keeps the others.
// - a duplicate flag copy serves the second master and clears only on its own reads.
// - host flags live at 0xB8 upward, duplicates at 0xC0 upward, none for slots 0xBA and 0xBF.
// - the alert output asserts when any unmasked flag bit becomes set.
// - alert stays low while a reading is out of range and until its register is read.
// - a set mask bit keeps its flag bit from asserting the alert.
// - masking changes only the alert; masked flags still set and hold.
// - each fan output is a square wave of programmable duty cycle.
// - a three wire fan on modulated drive gets pulse stretching for fan speed measurement.
// - in high frequency drive the fan speed pulse input is always valid, with no stretching.
// - eight fan speed pulse inputs pair with four outputs and are synchronized to the clock.
`timescale 1ns/10ps
module lsau_core #(
	parameter int HF_DIV = 1,
	parameter int LF_DIV = 64,
	parameter int STRETCH_CYCLES = 256
) (
	input wire logic CLOCK,
	input wire logic NRST,
	// register access port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// comparison results, one byte per flag register, one means out of limit
	input wire logic [8*lsau_pkg::NUM_STATUS-1:0] LIMIT_FAULT,
	// fan drive settings
	input wire logic [8*lsau_pkg::NUM_FAN_OUT-1:0] FAN_DUTY,
	input wire logic [lsau_pkg::NUM_FAN_OUT-1:0] FAN_HF_MODE,
	input wire logic [lsau_pkg::NUM_FAN_OUT-1:0] FAN_STRETCH_EN,
	input wire logic [lsau_pkg::NUM_FAN_IN-1:0] FAN_SPEED_PULSE_INPUT,
	output logic [lsau_pkg::NUM_FAN_OUT-1:0] FAN_DRIVE,
	output logic [lsau_pkg::NUM_FAN_IN-1:0] FAN_SPEED_VALID,
	output logic FAN_SPEED_PULSE_SYNC_DUMMY,
	output logic ALERT_N
);
	localparam int NS = lsau_pkg::NUM_STATUS;
	localparam int NF = lsau_pkg::NUM_FAN_OUT;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	// slot index of a host flag address, or NS when not a host flag
	function automatic int host_slot(input logic [7:0] a);
		host_slot = NS;
		if (a >= lsau_pkg::HOST_BASE && a < lsau_pkg::HOST_BASE + 8'(NS)) begin
			host_slot = int'(a - lsau_pkg::HOST_BASE);
		end
	endfunction : host_slot

	// slot index of a duplicate flag address, or NS when absent
	function automatic int second_slot(input logic [7:0] a);
		int s;
		s = NS;
		if (a >= lsau_pkg::SECOND_BASE && a < lsau_pkg::SECOND_BASE + 8'(NS)) begin
			s = int'(a - lsau_pkg::SECOND_BASE);
			if (!lsau_pkg::DUP_PRESENT[s]) begin
				s = NS;
			end
		end
		second_slot = s;
	endfunction : second_slot

	// mask slot for a flag slot, gpio is last mask, thermal three shares thermal two
	function automatic int mask_slot(input int s);
		if (s == lsau_pkg::GPIO_SLOT) begin
			mask_slot = lsau_pkg::NUM_MASK - 1;
		end else if (s > lsau_pkg::THERMAL_THREE_SLOT) begin
			mask_slot = s - 1;
		end else begin
			mask_slot = (s == lsau_pkg::THERMAL_THREE_SLOT) ? 1 : s;
		end
	endfunction : mask_slot

	int rd_host;
	int rd_second;
	int wr_mask;
	assign rd_host = REG_RD ? host_slot(REG_ADDR) : NS;
	assign rd_second = REG_RD ? second_slot(REG_ADDR) : NS;
	assign wr_mask = (REG_WR && REG_ADDR >= lsau_pkg::MASK_BASE &&
		REG_ADDR < lsau_pkg::MASK_BASE + 8'(lsau_pkg::NUM_MASK)) ?
		int'(REG_ADDR - lsau_pkg::MASK_BASE) : lsau_pkg::NUM_MASK;

	// ---------------------------------------------------------------
	// mask registers
	// ---------------------------------------------------------------
	logic [7:0] mask_reg [lsau_pkg::NUM_MASK];

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < lsau_pkg::NUM_MASK; i++) begin
				mask_reg[i] <= lsau_pkg::MASK_RESET;
			end
		end else if (wr_mask < lsau_pkg::NUM_MASK) begin
			mask_reg[wr_mask] <= REG_WDATA;
		end
	end

	// ---------------------------------------------------------------
	// sticky flags, host and duplicate copies
	// ---------------------------------------------------------------
	logic [7:0] host_reg [NS];
	logic [7:0] second_reg [NS];
	logic [NS-1:0] unmasked_any;

	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_flags
			logic [7:0] fault;
			assign fault = LIMIT_FAULT[8*g +: 8];
			// read keeps bits still in fault, new faults always set
			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					host_reg[g] <= lsau_pkg::FLAGS_RESET;
				end else if (rd_host == g) begin
					host_reg[g] <= fault;
				end else begin
					host_reg[g] <= host_reg[g] | fault;
				end
			end
			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					second_reg[g] <= lsau_pkg::FLAGS_RESET;
				end else if (!lsau_pkg::DUP_PRESENT[g]) begin
					second_reg[g] <= lsau_pkg::FLAGS_RESET;
				end else if (rd_second == g) begin
					second_reg[g] <= fault;
				end else begin
					second_reg[g] <= second_reg[g] | fault;
				end
			end
			assign unmasked_any[g] = |(host_reg[g] & ~mask_reg[mask_slot(g)]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// alert output
	// ---------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			ALERT_N <= 1'b1;
		end else begin
			ALERT_N <= ~(|unmasked_any);
		end
	end

	// ---------------------------------------------------------------
	// register read data
	// ---------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			REG_RDATA <= lsau_pkg::READ_UNMAPPED;
		end else if (REG_RD) begin
			if (host_slot(REG_ADDR) < NS) begin
				REG_RDATA <= host_reg[host_slot(REG_ADDR)];
			end else if (second_slot(REG_ADDR) < NS) begin
				REG_RDATA <= second_reg[second_slot(REG_ADDR)];
			end else if (REG_ADDR >= lsau_pkg::MASK_BASE &&
				REG_ADDR < lsau_pkg::MASK_BASE + 8'(lsau_pkg::NUM_MASK)) begin
				REG_RDATA <= mask_reg[int'(REG_ADDR - lsau_pkg::MASK_BASE)];
			end else begin
				REG_RDATA <= lsau_pkg::READ_UNMAPPED;
			end
		end
	end

	// ---------------------------------------------------------------
	// fan speed pulse input synchronisers
	// ---------------------------------------------------------------
	logic [lsau_pkg::NUM_FAN_IN-1:0] tp_s1;
	logic [lsau_pkg::NUM_FAN_IN-1:0] tp_s2;
	logic [lsau_pkg::NUM_FAN_IN-1:0] tp_s3;
	logic [lsau_pkg::NUM_FAN_IN-1:0] tp_level;

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			tp_s1 <= '0;
			tp_s2 <= '0;
			tp_s3 <= '0;
			tp_level <= '0;
		end else begin
			tp_s1 <= FAN_SPEED_PULSE_INPUT;
			tp_s2 <= tp_s1;
			tp_s3 <= tp_s2;
			for (int i = 0; i < lsau_pkg::NUM_FAN_IN; i++) begin
				if (tp_s2[i] == tp_s3[i]) begin
					tp_level[i] <= tp_s3[i];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// fan drive, duty-cycle square wave with pulse stretching
	// ---------------------------------------------------------------
	generate
		for (g = 0; g < NF; g++) begin : g_fan
			logic [15:0] pre_reg;
			logic [7:0] phase_reg;
			logic [15:0] stretch_reg;
			logic prev_reg;
			logic [15:0] div;
			logic pair_edge;
			assign div = FAN_HF_MODE[g] ? 16'(HF_DIV) : 16'(LF_DIV);
			// each output drives the pair of inputs 2g and 2g+1
			assign pair_edge = tp_level[2*g] | tp_level[2*g+1];
			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					pre_reg <= '0;
					phase_reg <= '0;
				end else if (pre_reg + 16'h0001 >= div) begin
					pre_reg <= '0;
					phase_reg <= phase_reg + 8'h01;
				end else begin
					pre_reg <= pre_reg + 16'h0001;
				end
			end
			// stretch holds the drive on for a whole measurement on each cycle start
			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					stretch_reg <= '0;
					prev_reg <= 1'b0;
				end else begin
					prev_reg <= pair_edge;
					if (!FAN_HF_MODE[g] && FAN_STRETCH_EN[g] && phase_reg == 8'h00 &&
						pre_reg == 16'h0000) begin
						stretch_reg <= 16'(STRETCH_CYCLES);
					end else if (stretch_reg != 16'h0000) begin
						stretch_reg <= stretch_reg - 16'h0001;
					end
				end
			end
			always_ff @(posedge CLOCK or negedge NRST) begin
				if (!NRST) begin
					FAN_DRIVE[g] <= 1'b0;
					FAN_SPEED_VALID[2*g] <= 1'b0;
					FAN_SPEED_VALID[2*g+1] <= 1'b0;
				end else begin
					FAN_DRIVE[g] <= (phase_reg < FAN_DUTY[8*g +: 8]) ||
						(FAN_DUTY[8*g +: 8] == lsau_pkg::DUTY_RESET) ||
						(stretch_reg != 16'h0000);
					FAN_SPEED_VALID[2*g] <= FAN_HF_MODE[g] || (stretch_reg != 16'h0000);
					FAN_SPEED_VALID[2*g+1] <= FAN_HF_MODE[g] || (stretch_reg != 16'h0000);
				end
			end
		end
	endgenerate

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			FAN_SPEED_PULSE_SYNC_DUMMY <= 1'b0;
		end else begin
			FAN_SPEED_PULSE_SYNC_DUMMY <= |tp_level;
		end
	end
endmodule : lsau_core

/* File: lsau_asserts.sv */
// checker: concurrent assertions on the register port and alert of lsau_core
`timescale 1ns/10ps
module lsau_asserts (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic [8*lsau_pkg::NUM_STATUS-1:0] LIMIT_FAULT,
	input wire logic ALERT_N
);
	// ---------------------------------------------------------------
	// shadow of mask writes
	// ---------------------------------------------------------------
	logic [6:0] full_reg;
	logic [6:0] nz_reg;
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			full_reg <= 7'h00;
			nz_reg <= 7'h00;
		end else if (REG_WR && REG_ADDR >= 8'h30 && REG_ADDR <= 8'h36) begin
			full_reg[REG_ADDR[2:0]] <= (REG_WDATA == 8'hFF);
			nz_reg[REG_ADDR[2:0]] <= (REG_WDATA != 8'h00);
		end
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	a_read_sets: assert property (REG_RD && REG_ADDR == 8'hB8 && $past(NRST)
		&& $past(LIMIT_FAULT[0]) |=> REG_RDATA[0]) else $error("host flag missed");
	a_second_sets: assert property (REG_RD && REG_ADDR == 8'hC0 && $past(NRST)
		&& $past(LIMIT_FAULT[1]) |=> REG_RDATA[1]) else $error("second flag missed");
	a_clear_gone: assert property (REG_RD && REG_ADDR == 8'hB8 && !LIMIT_FAULT[0]
		##1 REG_RD && REG_ADDR == 8'hB8 |=> !REG_RDATA[0]) else $error("flag not cleared");
	a_unmapped_zero: assert property (REG_RD && (REG_ADDR == 8'hC2 || REG_ADDR == 8'hC7)
		|=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
	a_alert_sticky: assert property (!ALERT_N && !REG_RD && !REG_WR && !$past(REG_RD)
		&& !$past(REG_WR) |=> !ALERT_N) else $error("alert released without read");
	a_alert_raised: assert property (nz_reg == 7'h00 && !REG_WR && (|LIMIT_FAULT)
		##1 !REG_WR |-> ##1 !ALERT_N) else $error("alert not raised");
	a_masked_quiet: assert property (full_reg == 7'h7F && $past(full_reg) == 7'h7F
		|-> ALERT_N) else $error("masked flag raised alert");
	a_masked_flag: assert property (REG_RD && REG_ADDR == 8'hBD && full_reg == 7'h7F
		&& $past(NRST) && $past(LIMIT_FAULT[40]) |=> REG_RDATA[0]) else $error("masked flag lost");
endmodule : lsau_asserts
bind lsau_core lsau_asserts u_lsau_asserts (.CLOCK(CLOCK), .NRST(NRST), .REG_ADDR(REG_ADDR),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.LIMIT_FAULT(LIMIT_FAULT), .ALERT_N(ALERT_N));

/* File: lsau_master.sv */
// partner: register master issuing one- or two-cycle read strobes and one-cycle write strobes
`timescale 1ns/10ps
module lsau_master (
	input wire logic CLOCK,
	output logic [7:0] REG_ADDR,
	output logic REG_WR,
	output logic REG_RD,
	output logic [7:0] REG_WDATA
);
	// ---------------------------------------------------------------
	// accesses; idle bus shows the inverse of the last value
	// ---------------------------------------------------------------
	initial begin
		REG_ADDR = 8'hFF;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_WDATA = 8'hFF;
	end
	task automatic rd(input logic [7:0] a0, input logic [7:0] a1, input bit two);
		@(posedge CLOCK);
		#2;
		REG_ADDR = a0;
		REG_RD = 1'b1;
		@(posedge CLOCK);
		#2;
		if (two) begin
			REG_ADDR = a1;
			@(posedge CLOCK);
			#2;
		end
		REG_RD = 1'b0;
		REG_ADDR = ~REG_ADDR;
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		#2;
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(posedge CLOCK);
		#2;
		REG_WR = 1'b0;
		REG_ADDR = ~a;
		REG_WDATA = ~d;
	endtask : wr
endmodule : lsau_master

/* File: lsau_core_tb.sv */
// testbench: self-checking bench for lsau_core driven by a register master
`timescale 1ns/10ps
module lsau_core_tb;
	logic CLOCK = 1'b0;
	logic NRST = 1'b0;
	logic [7:0] REG_ADDR;
	logic REG_WR;
	logic REG_RD;
	logic [7:0] REG_WDATA;
	logic [7:0] REG_RDATA;
	logic [63:0] LIMIT_FAULT = '0;
	logic [31:0] FAN_DUTY = '0;
	logic [3:0] FAN_HF_MODE = '0;
	logic [3:0] FAN_STRETCH_EN = '0;
	logic [3:0] FAN_DRIVE;
	logic [7:0] FAN_SPEED_VALID;
	logic [7:0] FAN_SPEED_PULSE_INPUT = '0;
	logic FAN_SPEED_PULSE_SYNC_DUMMY;
	logic ALERT_N;
	logic rd_d = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] v;
	logic [31:0] seed = 32'h911C;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	int hi2 = 0;
	int hi3 = 0;
	initial forever #50 CLOCK = ~CLOCK;
	lsau_master u_lsau_master (.CLOCK(CLOCK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_WDATA(REG_WDATA));
	lsau_core #(.HF_DIV(1), .LF_DIV(1), .STRETCH_CYCLES(8)) u_lsau_core (.CLOCK(CLOCK),
		.NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .LIMIT_FAULT(LIMIT_FAULT),
		.FAN_DUTY(FAN_DUTY), .FAN_HF_MODE(FAN_HF_MODE), .FAN_STRETCH_EN(FAN_STRETCH_EN),
		.FAN_SPEED_PULSE_INPUT(FAN_SPEED_PULSE_INPUT), .FAN_DRIVE(FAN_DRIVE),
		.FAN_SPEED_VALID(FAN_SPEED_VALID),
		.FAN_SPEED_PULSE_SYNC_DUMMY(FAN_SPEED_PULSE_SYNC_DUMMY), .ALERT_N(ALERT_N));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("unexpected at %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
		#2;
	endtask : tick
	// two back-to-back reads of one address, results noted in order
	task automatic rd2(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
		exp_q.push_back(e0);
		exp_q.push_back(e1);
		u_lsau_master.rd(a, a, 1'b1);
	endtask : rd2
	// read results are compared the edge after each taken read
	always @(posedge CLOCK) begin
		if (rd_d === 1'b1)
			check(REG_RDATA, exp_q.pop_front());
		rd_d <= REG_RD;
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			end_sim();
		end
	end
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		tick(10);
		NRST = 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd2(8'h30 + i[7:0], 8'h00, 8'h00);
			rd2(8'hB8 + i[7:0], 8'h00, 8'h00);
		end
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			v = seed[7:0] | 8'h01;
			LIMIT_FAULT[8*i +: 8] = v;
			tick(1);
			LIMIT_FAULT = '0;
			tick(3);
			check(ALERT_N, 8'h00);
			rd2(8'hB8 + i[7:0], v, 8'h00);
			tick(1);
			check(ALERT_N, 8'h01);
			rd2(8'hC0 + i[7:0], lsau_pkg::DUP_PRESENT[i] ? v : 8'h00, 8'h00);
		end
		LIMIT_FAULT[7:0] = 8'h5A;
		tick(2);
		rd2(8'hB8, 8'h5A, 8'h5A);
		rd2(8'hC0, 8'h5A, 8'h5A);
		LIMIT_FAULT = '0;
		rd2(8'hB8, 8'h5A, 8'h00);
		for (int i = 0; i < 7; i++) begin
			u_lsau_master.wr(8'h30 + i[7:0], 8'hFF);
			rd2(8'h30 + i[7:0], 8'hFF, 8'hFF);
		end
		seed = xs(seed);
		LIMIT_FAULT = {seed | 32'h0100, seed | 32'h0001};
		tick(3);
		check(ALERT_N, 8'h01);
		u_lsau_master.wr(8'hBD, 8'h00);
		u_lsau_master.wr(8'h37, 8'hFF);
		rd2(8'h37, 8'h00, 8'h00);
		rd2(8'hBD, LIMIT_FAULT[47:40], LIMIT_FAULT[47:40]);
		u_lsau_master.wr(8'h30, 8'h00);
		tick(2);
		check(ALERT_N, 8'h00);
		LIMIT_FAULT = '0;
		rd2(8'hB8, seed[7:0] | 8'h01, 8'h00);
		tick(1);
		check(ALERT_N, 8'h01);
		FAN_HF_MODE = 4'b0011;
		FAN_DUTY = 32'h0000_FF00;
		FAN_STRETCH_EN = 4'b0100;
		tick(4);
		check(FAN_DRIVE[1:0], 8'h02);
		check(FAN_SPEED_VALID[3:0], 8'h0F);
		for (int c = 0; c < 600; c++) begin
			tick(1);
			hi2 += (FAN_DRIVE[2] === 1'b1);
			hi3 += (FAN_DRIVE[3] !== 1'b0);
		end
		check(hi2 > 0, 8'h01);
		check(hi3 != 0, 8'h00);
		// speed pulses pass three flops and the level register, then the registered or
		seed = xs(seed);
		FAN_SPEED_PULSE_INPUT = seed[7:0] | 8'h01;
		tick(6);
		check(FAN_SPEED_PULSE_SYNC_DUMMY, 8'h01);
		FAN_SPEED_PULSE_INPUT = 8'h00;
		tick(6);
		check(FAN_SPEED_PULSE_SYNC_DUMMY, 8'h00);
		tick(3);
		end_sim();
	end
endmodule : lsau_core_tb
